// >>> logic/tracker_discrete_io_triggers.sv
// Purpose: discrete input triggers, emergency button, lamp, outputs and serial settings of a tracker
// Assumes: single clock at 200 MHz, asynchronous active-high reset
// Notes: tracking-mode internals live elsewhere; this block raises mode requests and report pulses
//
// Overview of operation
// (R1) unconnected inputs read high via pull-ups
// (R2) per-input function and edge trigger configurable
// (R3) emergency input edge enters emergency tracking
// (R4) test input edge enters test tracking
// (R5) general input edge queues one input report
// (R6) all input levels offered to position reports
// (R7) reset: line0 emergency/fall, line1 test/fall
// (R8) push-button combined with input line zero
// (R9) momentary press starts; three-second hold ends
// (R10) lamp lit exactly while emergency tracking
// (R11) momentary or latching style; latching follows level
// (R12) report enable: pin change sends value notice
// (R13) outputs follow host command or remote update
// (R14) serial link is three wires, no handshake
// (R15) no autobaud; starts at 19.2 kbps
// (R16) bit rate reprogrammable, 4.8 to 115.2 kbps
// (R17) report trigger sends reports, then normal tracking
// (R18) inputs synchronised, edges become one-cycle pulses
// (R19) hold counter restarts on release, fires once
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tracker_discrete_io_triggers #(
  parameter int HOLD_CYCLES = dio_pkg::HOLD_EXIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // discrete pins
  input wire logic [dio_pkg::NUM_IN-1:0] input_line,
  input wire logic emergency_button_n,
  output logic [dio_pkg::NUM_OUT-1:0] discrete_out,
  output logic emergency_lamp,
  // remote configuration update
  input wire logic remote_out_valid,
  input wire logic [dio_pkg::NUM_OUT-1:0] remote_out_value,
  // tracking engine and serial side
  output dio_pkg::track_t track_mode,
  output logic input_report_pulse,
  output logic [dio_pkg::NUM_IN-1:0] report_levels,
  output logic input_value_notice,
  output dio_pkg::notice_t notice_data,
  output logic [15:0] baud_div,
  // interrupt
  output logic irq
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  localparam int NI = dio_pkg::NUM_IN;
  localparam int NP = NI + 1;

  logic [NP-1:0] lvl;
  logic [NP-1:0] rise;
  logic [NP-1:0] fall;

  pin_sync_edge #(.WIDTH(NP), .RESET_LEVEL({NP{1'b1}})) u_sync (
    .clk(clk),
    .reset(reset),
    .pin({emergency_button_n, input_line}), // [R1] [R18]
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  wire logic [NI-1:0] in_lvl = lvl[NI-1:0];
  wire logic btn_lvl = lvl[NI];
  wire logic btn_press = fall[NI];
  wire logic btn_release = rise[NI];

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  dio_pkg::in_cfg_t cfg_r [NI];
  logic report_en_r;
  logic style_latch_r;
  logic [dio_pkg::NUM_OUT-1:0] out_r;
  logic [15:0] baud_r;
  logic [dio_pkg::IRQ_BITS-1:0] irq_status_r;
  logic [dio_pkg::IRQ_BITS-1:0] irq_enable_r;
  logic [15:0] report_cnt_r;

  wire logic wr_cfg = reg_wr && (reg_addr == dio_pkg::REG_IN_CFG);
  wire logic wr_ctrl = reg_wr && (reg_addr == dio_pkg::REG_CTRL);
  wire logic wr_out = reg_wr && (reg_addr == dio_pkg::REG_OUT);
  wire logic wr_baud = reg_wr && (reg_addr == dio_pkg::REG_BAUD);
  wire logic wr_ien = reg_wr && (reg_addr == dio_pkg::REG_IRQ_ENABLE);
  wire logic wr_iclr = reg_wr && (reg_addr == dio_pkg::REG_IRQ_CLEAR);
  wire logic wr_rcnt = reg_wr && (reg_addr == dio_pkg::REG_REPORT_CNT);
  wire logic track_done = wr_ctrl && reg_wdata[dio_pkg::CTRL_TRACK_DONE];

  // rate outside the supported range is ignored rather than clamped [R15] [R16]
  wire logic [15:0] baud_w = reg_wdata[15:0];
  wire logic baud_ok = (baud_w >= dio_pkg::BAUD_DIV_MIN) && (baud_w <= dio_pkg::BAUD_DIV_MAX);

  function automatic dio_pkg::in_cfg_t cfg_reset(input int idx);
    if (idx == 0) begin
      return dio_pkg::CFG_LINE0_RESET;
    end else if (idx == 1) begin
      return dio_pkg::CFG_LINE1_RESET;
    end
    return dio_pkg::CFG_OTHER_RESET;
  endfunction

  // does a line's configured edge fire this cycle
  function automatic logic edge_hit(input dio_pkg::edge_t e, input logic r, input logic f);
    case (e)
      dio_pkg::EDGE_RISE: edge_hit = r;
      dio_pkg::EDGE_FALL: edge_hit = f;
      dio_pkg::EDGE_BOTH: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  logic [NI-1:0] hit;
  logic [NI-1:0] is_emerg;
  logic [NI-1:0] is_test;
  logic [NI-1:0] is_gen;
  logic [NI-1:0] emerg_active_lvl;

  genvar g;
  generate
    for (g = 0; g < NI; g++) begin : g_line
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          cfg_r[g] <= cfg_reset(g); // [R7]
        end else if (wr_cfg) begin
          cfg_r[g] <= dio_pkg::in_cfg_t'(reg_wdata[g*dio_pkg::CFG_BITS +: dio_pkg::CFG_BITS]); // [R2]
        end
      end
      // line 0 also sees the push-button edges [R8]
      wire logic r_g = (g == 0) ? (rise[g] | btn_release) : rise[g];
      wire logic f_g = (g == 0) ? (fall[g] | btn_press) : fall[g];
      assign hit[g] = edge_hit(cfg_r[g].edge_sel, r_g, f_g); // [R2]
      assign is_emerg[g] = cfg_r[g].func == dio_pkg::FUNC_EMERG;
      assign is_test[g] = cfg_r[g].func == dio_pkg::FUNC_TEST;
      assign is_gen[g] = cfg_r[g].func == dio_pkg::FUNC_GENERAL;
      // latching: trigger is active while the level sits past the edge
      // lines set to both edges or to none never latch
      wire logic l_g = (g == 0) ? (in_lvl[g] & btn_lvl) : in_lvl[g];
      assign emerg_active_lvl[g] = is_emerg[g] && (
        (cfg_r[g].edge_sel == dio_pkg::EDGE_FALL && !l_g) ||
        (cfg_r[g].edge_sel == dio_pkg::EDGE_RISE && l_g)); // [R11]
    end
  endgenerate

  wire logic emerg_hit = |(hit & is_emerg); // [R3]
  wire logic test_hit = |(hit & is_test); // [R4]
  wire logic gen_hit = |(hit & is_gen); // [R5]
  wire logic emerg_level = |emerg_active_lvl;

  // ----------------------------------------
  // button hold timer
  // ----------------------------------------
  localparam int HW = $clog2(HOLD_CYCLES + 1);
  logic [HW-1:0] hold_r;
  logic hold_fired_r;
  // limitation: the count runs from the press in any mode, so in momentary style one long press
  // both enters and then leaves emergency tracking
  // counts only while pressed; release restarts it [R19]
  wire logic [HW-1:0] hold_nxt = btn_lvl ? '0 : (hold_fired_r ? hold_r : hold_r + HW'(1));
  wire logic hold_exit = !btn_lvl && !hold_fired_r && (hold_r == HW'(HOLD_CYCLES - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_r <= '0;
      hold_fired_r <= 1'b0;
    end else begin
      hold_r <= hold_nxt;
      hold_fired_r <= btn_lvl ? 1'b0 : (hold_fired_r | hold_exit); // [R19]
    end
  end

  // ----------------------------------------
  // tracking mode machine
  // ----------------------------------------
  dio_pkg::track_t mode_r;
  dio_pkg::track_t mode_nxt;
  wire logic latching = style_latch_r != dio_pkg::CTRL_STYLE_MOMENTARY;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      dio_pkg::TRK_NORMAL: begin
        if (latching ? emerg_level : emerg_hit) begin
          mode_nxt = dio_pkg::TRK_EMERG; // [R3] [R11]
        end else if (test_hit) begin
          mode_nxt = dio_pkg::TRK_TEST; // [R4]
        end else if (gen_hit) begin
          mode_nxt = dio_pkg::TRK_REPORT; // [R17]
        end
      end
      dio_pkg::TRK_EMERG: begin
        // other triggers are dropped here, not held over
        if (latching ? !emerg_level : hold_exit) begin
          mode_nxt = dio_pkg::TRK_NORMAL; // [R9] [R11]
        end
      end
      dio_pkg::TRK_TEST, dio_pkg::TRK_REPORT: begin
        if (latching ? emerg_level : emerg_hit) begin
          mode_nxt = dio_pkg::TRK_EMERG; // emergency preempts other tracking [R3]
        end else if (track_done) begin
          mode_nxt = dio_pkg::TRK_NORMAL; // [R17]
        end
      end
      default: mode_nxt = dio_pkg::TRK_NORMAL;
    endcase
  end

  // ----------------------------------------
  // value notice
  // ----------------------------------------
  wire logic [NI-1:0] any_change = rise[NI-1:0] | fall[NI-1:0];
  // the level register lags the edge pulse by one cycle, so the notice
  // carries the level the pin has just moved to
  wire logic [NI-1:0] in_lvl_new = in_lvl ^ any_change;
  wire logic notice_fire = report_en_r && (|any_change); // [R12]
  logic notice_r;
  dio_pkg::notice_t notice_data_r;

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  logic [dio_pkg::IRQ_BITS-1:0] ev;
  assign ev[dio_pkg::IRQ_EMERG_ON] = (mode_nxt == dio_pkg::TRK_EMERG) && (mode_r != dio_pkg::TRK_EMERG);
  assign ev[dio_pkg::IRQ_EMERG_OFF] = (mode_r == dio_pkg::TRK_EMERG) && (mode_nxt != dio_pkg::TRK_EMERG);
  assign ev[dio_pkg::IRQ_TEST_ON] = (mode_nxt == dio_pkg::TRK_TEST) && (mode_r != dio_pkg::TRK_TEST);
  assign ev[dio_pkg::IRQ_GENERAL] = gen_hit;
  assign ev[dio_pkg::IRQ_VALUE_NOTICE] = notice_fire;

  // set beats a clear landing in the same cycle
  wire logic [dio_pkg::IRQ_BITS-1:0] clr = wr_iclr ? reg_wdata[dio_pkg::IRQ_BITS-1:0] : '0;
  wire logic [dio_pkg::IRQ_BITS-1:0] irq_status_nxt = (irq_status_r & ~clr) | ev;

  // queued report count saturates; software drains it with a write [R5]
  wire logic [15:0] rcnt_dec = wr_rcnt ? reg_wdata[15:0] : 16'h0000;
  wire logic [15:0] rcnt_base = (rcnt_dec > report_cnt_r) ? 16'h0000 : report_cnt_r - rcnt_dec;
  wire logic [15:0] report_cnt_nxt = (gen_hit && rcnt_base != 16'hffff) ? rcnt_base + 16'h0001 : rcnt_base;

  // ----------------------------------------
  // state and register updates
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= dio_pkg::TRK_NORMAL;
      report_en_r <= 1'b0;
      style_latch_r <= dio_pkg::CTRL_STYLE_MOMENTARY;
      out_r <= '0;
      baud_r <= dio_pkg::BAUD_DIV_DEFAULT; // [R15]
      irq_status_r <= '0;
      irq_enable_r <= '0;
      report_cnt_r <= '0;
      notice_r <= 1'b0;
      notice_data_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      irq_status_r <= irq_status_nxt;
      report_cnt_r <= report_cnt_nxt;
      notice_r <= notice_fire; // [R12]
      if (notice_fire) begin
        notice_data_r <= '{levels: in_lvl_new, changed: any_change}; // [R12]
      end
      if (wr_ctrl) begin
        report_en_r <= reg_wdata[dio_pkg::CTRL_REPORT_EN];
        style_latch_r <= reg_wdata[dio_pkg::CTRL_STYLE]; // [R11]
      end
      // remote update wins when both land together, being the newer intent
      if (remote_out_valid) begin
        out_r <= remote_out_value; // [R13]
      end else if (wr_out) begin
        out_r <= reg_wdata[dio_pkg::NUM_OUT-1:0]; // [R13]
      end
      if (wr_baud && baud_ok) begin
        baud_r <= baud_w; // [R16]
      end
      if (wr_ien) begin
        irq_enable_r <= reg_wdata[dio_pkg::IRQ_BITS-1:0];
      end
    end
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;
  logic [NI*dio_pkg::CFG_BITS-1:0] cfg_flat;

  generate
    for (g = 0; g < NI; g++) begin : g_flat
      assign cfg_flat[g*dio_pkg::CFG_BITS +: dio_pkg::CFG_BITS] = cfg_r[g];
    end
  endgenerate

  always_comb begin
    case (reg_addr)
      dio_pkg::REG_IN_CFG: rd_mux = 32'(cfg_flat);
      dio_pkg::REG_CTRL: rd_mux = 32'({style_latch_r, report_en_r});
      dio_pkg::REG_OUT: rd_mux = 32'(out_r);
      dio_pkg::REG_BAUD: rd_mux = 32'(baud_r);
      dio_pkg::REG_IN_LEVEL: rd_mux = 32'(in_lvl); // [R6]
      dio_pkg::REG_MODE: rd_mux = 32'(mode_r);
      dio_pkg::REG_IRQ_STATUS: rd_mux = 32'(irq_status_r);
      dio_pkg::REG_IRQ_ENABLE: rd_mux = 32'(irq_enable_r);
      dio_pkg::REG_REPORT_CNT: rd_mux = 32'(report_cnt_r);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_r;
  assign discrete_out = out_r; // [R13]
  assign emergency_lamp = mode_r == dio_pkg::TRK_EMERG; // [R10]
  assign track_mode = mode_r;
  assign input_report_pulse = gen_hit; // [R5]
  assign report_levels = in_lvl; // [R6]
  assign input_value_notice = notice_r;
  assign notice_data = notice_data_r;
  assign baud_div = baud_r; // [R14] [R15]
  assign irq = |(irq_status_r & irq_enable_r);

endmodule // tracker_discrete_io_triggers

// >>> pkg/dio_pkg.sv
// Purpose: shared constants and types for the discrete input/output trigger block
// Assumes: 200 MHz system clock
// Notes: register map sits on a plain strobe port
package dio_pkg;

  localparam int CLK_HZ = 200_000_000;
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 3;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int HOLD_EXIT_MS = 3000;
  localparam int HOLD_EXIT_CYCLES = HOLD_EXIT_MS * (CLK_HZ / 1000);
  localparam int BAUD_DEFAULT_BPS = 19200;
  localparam int BAUD_MIN_BPS = 4800;
  localparam int BAUD_MAX_BPS = 115200;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'((CLK_HZ + BAUD_DEFAULT_BPS / 2) / BAUD_DEFAULT_BPS);
  localparam logic [15:0] BAUD_DIV_MIN = 16'(CLK_HZ / BAUD_MAX_BPS);
  localparam logic [15:0] BAUD_DIV_MAX = 16'(CLK_HZ / BAUD_MIN_BPS);

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] REG_IN_CFG = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_OUT = 8'h08;
  localparam logic [7:0] REG_BAUD = 8'h0c;
  localparam logic [7:0] REG_IN_LEVEL = 8'h10;
  localparam logic [7:0] REG_MODE = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h20;
  localparam logic [7:0] REG_REMOTE_OUT = 8'h24;
  localparam logic [7:0] REG_REPORT_CNT = 8'h28;

  // ----------------------------------------
  // field layouts
  // ----------------------------------------
  localparam int CFG_BITS = 4;
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_EDGE_LSB = 2;
  localparam int CTRL_REPORT_EN = 0;
  localparam int CTRL_STYLE = 1;
  localparam int CTRL_TRACK_DONE = 2;
  localparam int IRQ_BITS = 5;
  localparam int IRQ_EMERG_ON = 0;
  localparam int IRQ_EMERG_OFF = 1;
  localparam int IRQ_TEST_ON = 2;
  localparam int IRQ_GENERAL = 3;
  localparam int IRQ_VALUE_NOTICE = 4;

  typedef enum logic [1:0] {
    FUNC_EMERG = 2'h0,
    FUNC_TEST = 2'h1,
    FUNC_GENERAL = 2'h2,
    FUNC_NONE = 2'h3
  } func_t;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_t;

  typedef struct packed {
    edge_t edge_sel;
    func_t func;
  } in_cfg_t;

  localparam in_cfg_t CFG_LINE0_RESET = '{edge_sel: EDGE_FALL, func: FUNC_EMERG};
  localparam in_cfg_t CFG_LINE1_RESET = '{edge_sel: EDGE_FALL, func: FUNC_TEST};
  localparam in_cfg_t CFG_OTHER_RESET = '{edge_sel: EDGE_NONE, func: FUNC_GENERAL};

  localparam logic CTRL_STYLE_MOMENTARY = 1'b0;

  // tracking modes, gray coded
  typedef enum logic [1:0] {
    TRK_NORMAL = 2'b00,
    TRK_EMERG = 2'b01,
    TRK_TEST = 2'b11,
    TRK_REPORT = 2'b10
  } track_t;

  typedef struct packed {
    logic [NUM_IN-1:0] levels;
    logic [NUM_IN-1:0] changed;
  } notice_t;

endpackage

// >>> logic/pin_sync_edge.sv
// Purpose: three-stage pin synchroniser with rise and fall pulses
// Assumes: pin is asynchronous to clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module pin_sync_edge #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins
  input wire logic [WIDTH-1:0] pin,
  // synchronised view
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;
  wire logic [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

  // pulled-up pins idle high, so reset level is high [R1]
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= RESET_LEVEL;
      s2_r <= RESET_LEVEL;
      s3_r <= RESET_LEVEL;
      level_r <= RESET_LEVEL;
    end else begin
      meta_r <= pin;
      s2_r <= meta_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign level_nxt = (agree & s3_r) | (~agree & level_r);
  assign level = level_r;
  // one-cycle pulse per accepted edge [R18]
  assign rise = level_nxt & ~level_r;
  assign fall = ~level_nxt & level_r;

endmodule // pin_sync_edge

// >>> testbench/switch_bank.sv
// Purpose: switches and logic on the discrete input pins
// Assumes: bench selects which lines are actively driven
// Notes: a released line is never left floating
`timescale 1ns/1ps
module switch_bank (
  // commands from the bench
  input wire logic [3:0] drive_en,
  input wire logic [3:0] drive_val,
  input wire logic press,
  // pins
  output logic [3:0] input_line,
  output logic emergency_button_n
);
  // released lines go to the pull-up level
  assign input_line = (drive_en & drive_val) | ~drive_en;
  // guarded button shorts to ground while pressed
  assign emergency_button_n = ~press;
endmodule // switch_bank

// >>> testbench/dio_sva.sv
// Purpose: port-level assertions for the trigger block
// Assumes: one clock domain, async reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module dio_sva #(
  parameter int HOLD_CYCLES = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // pins and outputs
  input wire logic [3:0] input_line,
  input wire logic [2:0] discrete_out,
  input wire logic emergency_lamp,
  input wire logic remote_out_valid,
  input wire logic [2:0] remote_out_value,
  input wire dio_pkg::track_t track_mode,
  input wire logic input_report_pulse,
  input wire logic [3:0] report_levels,
  input wire logic input_value_notice,
  input wire logic [15:0] baud_div
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // line 0 is left out: it merges with the button
  sequence steady_s;
    $stable(input_line[3:1]) [*5];
  endsequence
  lamp_mode_a: assert property (emergency_lamp == (track_mode == dio_pkg::TRK_EMERG))
    else $error("lamp disagrees with mode");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  notice_once_a: assert property (input_value_notice |=> !input_value_notice)
    else $error("notice longer than one cycle");
  pulse_once_a: assert property (input_report_pulse |=> !input_report_pulse)
    else $error("report pulse longer than one cycle");
  baud_range_a: assert property (baud_div >= dio_pkg::BAUD_DIV_MIN && baud_div <= dio_pkg::BAUD_DIV_MAX)
    else $error("bit rate divider out of range");
  remote_out_a: assert property (remote_out_valid |=> discrete_out == $past(remote_out_value))
    else $error("remote update not applied");
  levels_sync_a: assert property (steady_s |-> report_levels[3:1] == input_line[3:1])
    else $error("levels do not follow pins");
  test_entry_a: assert property ($rose(track_mode == dio_pkg::TRK_TEST) |-> $past(track_mode) == dio_pkg::TRK_NORMAL)
    else $error("test mode entered from busy mode");
endmodule // dio_sva

bind tracker_discrete_io_triggers dio_sva #(.HOLD_CYCLES(HOLD_CYCLES)) u_sva (.clk, .reset, .reg_rd, .reg_rdata,
  .input_line, .discrete_out, .emergency_lamp, .remote_out_valid, .remote_out_value, .track_mode,
  .input_report_pulse, .report_levels, .input_value_notice, .baud_div);

// >>> testbench/tracker_discrete_io_triggers_tb.sv
// Purpose: self-checking bench for the discrete trigger block
// Assumes: button hold shortened to 50 cycles
// Notes: pins are driven through the switch model
`timescale 1ns/1ps
module tracker_discrete_io_triggers_tb;
  localparam int HOLD = 50;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] drive_en = 4'h0;
  logic [3:0] drive_val = 4'hf;
  logic press = 1'b0;
  logic remote_out_valid = 1'b0;
  logic [2:0] remote_out_value = 3'h0;
  logic [31:0] reg_rdata;
  logic [3:0] input_line, report_levels;
  logic emergency_button_n, emergency_lamp, input_report_pulse, input_value_notice, irq;
  logic [2:0] discrete_out;
  logic [15:0] baud_div;
  dio_pkg::track_t track_mode;
  dio_pkg::notice_t notice_data, last_notice;
  int n_errors = 0;
  int check_count = 0;
  int n_pulse = 0;
  int n_notice = 0;

  always #2.5 clk = ~clk;

  switch_bank u_pins (.drive_en, .drive_val, .press, .input_line, .emergency_button_n);
  tracker_discrete_io_triggers #(.HOLD_CYCLES(HOLD)) DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .input_line, .emergency_button_n, .discrete_out, .emergency_lamp, .remote_out_valid,
    .remote_out_value, .track_mode, .input_report_pulse, .report_levels, .input_value_notice, .notice_data,
    .baud_div, .irq);

  // single-cycle pulses are tallied as they pass
  always @(posedge clk) begin
    if (input_report_pulse === 1'b1)
      n_pulse <= n_pulse + 1;
    if (input_value_notice === 1'b1) begin
      n_notice <= n_notice + 1;
      last_notice <= notice_data;
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(what, reg_rdata, exp);
  endtask

  task automatic pins(input logic [3:0] en, input logic [3:0] v);
    @(posedge clk);
    drive_en <= en;
    drive_val <= v;
  endtask

  task automatic btn(input logic v);
    @(posedge clk);
    press <= v;
  endtask

  // a hung mode change ends the run instead of stalling it
  task automatic wait_mode(input dio_pkg::track_t m);
    for (int i = 0; i < 300 && track_mode !== m; i++) begin
      @(posedge clk);
      #1;
    end
    check("track_mode", track_mode, m);
    if (track_mode !== m)
      final_report();
  endtask

  task automatic hit(input logic [3:0] en, input logic [3:0] v);
    pins(en, v);
    wait_mode(dio_pkg::TRK_REPORT);
    wr(dio_pkg::REG_CTRL, 32'h4);
    wait_mode(dio_pkg::TRK_NORMAL);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rdc(dio_pkg::REG_IN_CFG, {16'h0, dio_pkg::CFG_OTHER_RESET, dio_pkg::CFG_OTHER_RESET,
      dio_pkg::CFG_LINE1_RESET, dio_pkg::CFG_LINE0_RESET}, "in_cfg");
    rdc(dio_pkg::REG_BAUD, {16'h0, dio_pkg::BAUD_DIV_DEFAULT}, "baud");
    rdc(dio_pkg::REG_IN_LEVEL, 32'hf, "levels");
    rdc(8'h24, 32'h0, "unmapped");
    $display("test reset done");
    wr(dio_pkg::REG_BAUD, {16'h0, dio_pkg::BAUD_DIV_MAX});
    wr(dio_pkg::REG_BAUD, {16'h0, dio_pkg::BAUD_DIV_MIN - 16'h1});
    rdc(dio_pkg::REG_BAUD, {16'h0, dio_pkg::BAUD_DIV_MAX}, "baud");
    check("baud_div", baud_div, {16'h0, dio_pkg::BAUD_DIV_MAX});
    $display("test baud done");
    wr(dio_pkg::REG_IRQ_ENABLE, 32'h1f);
    pins(4'h1, 4'he);
    wait_mode(dio_pkg::TRK_EMERG);
    check("lamp", emergency_lamp, 32'h1);
    check("irq", irq, 32'h1);
    pins(4'h0, 4'hf);
    btn(1'b1);
    wait_mode(dio_pkg::TRK_NORMAL);
    btn(1'b0);
    check("lamp", emergency_lamp, 32'h0);
    rdc(dio_pkg::REG_IRQ_STATUS, 32'h3, "irq_status");
    wr(dio_pkg::REG_IRQ_CLEAR, 32'h1f);
    @(posedge clk);
    #1 check("irq", irq, 32'h0);
    btn(1'b1);
    repeat (10) @(posedge clk);
    btn(1'b0);
    wait_mode(dio_pkg::TRK_EMERG);
    btn(1'b1);
    wait_mode(dio_pkg::TRK_NORMAL);
    btn(1'b0);
    $display("test emergency done");
    pins(4'h2, 4'hd);
    wait_mode(dio_pkg::TRK_TEST);
    pins(4'h0, 4'hf);
    wr(dio_pkg::REG_CTRL, 32'h4);
    wait_mode(dio_pkg::TRK_NORMAL);
    $display("test test-mode done");
    // line 2 general on both edges, line 3 general on rise only; lines 0 and 1 keep their reset setting
    wr(dio_pkg::REG_IN_CFG, 32'h6e98);
    hit(4'h4, 4'hb);
    hit(4'h0, 4'hf);
    wr(dio_pkg::REG_CTRL, 32'h1);
    pins(4'h8, 4'h7);
    for (int i = 0; i < 20 && n_notice == 0; i++)
      @(posedge clk);
    check("n_notice", n_notice, 32'h1);
    check("notice", last_notice, {24'h0, 4'h7, 4'h8});
    check("n_pulse", n_pulse, 32'h2);
    hit(4'h0, 4'hf);
    rdc(dio_pkg::REG_REPORT_CNT, 32'h3, "report_cnt");
    $display("test general done");
    wr(dio_pkg::REG_OUT, 32'h5);
    #1 check("out", discrete_out, 32'h5);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= dio_pkg::REG_OUT;
    reg_wdata <= 32'h7;
    remote_out_valid <= 1'b1;
    remote_out_value <= 3'h2;
    @(posedge clk);
    reg_wr <= 1'b0;
    remote_out_valid <= 1'b0;
    @(posedge clk);
    #1 check("out", discrete_out, 32'h2);
    $display("test outputs done");
    wr(dio_pkg::REG_CTRL, 32'h2);
    pins(4'h1, 4'he);
    wait_mode(dio_pkg::TRK_EMERG);
    pins(4'h0, 4'hf);
    wait_mode(dio_pkg::TRK_NORMAL);
    $display("test latching done");
    final_report();
  end
endmodule // tracker_discrete_io_triggers_tb
